//--- rtl/rsf_top.sv
// reading smoothing filter top: registers, channels, shutdown, interrupt
`timescale 1ns/1ps
module rsf_top
   import rsf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [5:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic [RSF_NIN-1:0] rdg_valid_i,
   input wire logic [RSF_NIN*RSF_DW-1:0] rdg_data_i,
   input wire logic [RSF_NIN-1:0] pref_valid_i,
   input wire logic [RSF_NIN*RSF_DW-1:0] pref_data_i,
   output logic [RSF_NIN-1:0] filt_valid_o,
   output logic [RSF_NIN*RSF_DW-1:0] filt_data_o,
   output logic [RSF_NIN-1:0] ctrl_valid_o,
   output logic [RSF_NIN*RSF_DW-1:0] ctrl_data_o,
   output logic ctrl_shutdown_o,
   output logic irq_o
);
   rsf_cfg_s cfg_q [RSF_NIN];
   logic [23:0] lim_q [RSF_NIN];
   logic [23:0] fs_q [RSF_NIN];
   logic [RSF_NIN-1:0] cfg_chg_q;
   logic mm_clr_q;
   logic [RSF_NIN-1:0] mask_q;
   logic [RSF_NIN-1:0] stat_q;
   logic [RSF_NIN-1:0] over;
   logic [RSF_NIN-1:0] restart;
   rsf_rdg_s filt [RSF_NIN];
   logic [23:0] mx [RSF_NIN];
   logic [23:0] mn [RSF_NIN];
   logic [31:0] rd_d;
   logic [1:0] idx;
   assign idx = addr_i[1:0];
   genvar g;
   generate
      for (g = 0; g < RSF_NIN; g++) begin : g_ch
         rsf_chan u_chan (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .cfg_i(cfg_q[g]),
            .cfg_chg_i(cfg_chg_q[g]),
            .mm_clr_i(mm_clr_q),
            .limit_i(lim_q[g]),
            .fs_i(fs_q[g]),
            .rdg_i({rdg_valid_i[g], rdg_data_i[g*RSF_DW +: RSF_DW]}),
            .pref_i({pref_valid_i[g], pref_data_i[g*RSF_DW +: RSF_DW]}),
            .filt_o(filt[g]),
            .max_o(mx[g]),
            .min_o(mn[g]),
            .over_o(over[g]),
            .restart_o(restart[g])
         );
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               ctrl_valid_o[g] <= 1'b0;
               ctrl_data_o[g*RSF_DW +: RSF_DW] <= 24'h000000;
            end else begin
               ctrl_valid_o[g] <= rdg_valid_i[g];
               if (rdg_valid_i[g]) begin
                  ctrl_data_o[g*RSF_DW +: RSF_DW] <= rdg_data_i[g*RSF_DW +: RSF_DW];
               end
            end
         end
         always_comb begin
            filt_valid_o[g] = filt[g].valid;
            filt_data_o[g*RSF_DW +: RSF_DW] = filt[g].value;
         end
      end
   endgenerate
   // configuration writes
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < RSF_NIN; i++) begin
            cfg_q[i] <= '{unit: RSF_U_KELVIN, window: RSF_WIN_RST, points: RSF_PTS_RST,
                          enable: 1'b0};
            lim_q[i] <= RSF_LIM_RST;
            fs_q[i] <= RSF_FS_RST;
         end
         cfg_chg_q <= '0;
         mm_clr_q <= 1'b0;
         mask_q <= '0;
      end else begin
         cfg_chg_q <= '0;
         mm_clr_q <= 1'b0;
         if (wr_i) begin
            case (addr_i & 6'h3c)
               RSF_REG_CFG0: begin
                  cfg_q[idx].enable <= wdata_i[RSF_CFG_EN_BIT];
                  if (wdata_i[RSF_CFG_PTS_LSB +: 7] >= RSF_PTS_MIN &&
                      wdata_i[RSF_CFG_PTS_LSB +: 7] <= RSF_PTS_MAX) begin
                     cfg_q[idx].points <= wdata_i[RSF_CFG_PTS_LSB +: 7];
                  end
                  if (wdata_i[RSF_CFG_WIN_LSB +: 4] >= RSF_WIN_MIN &&
                      wdata_i[RSF_CFG_WIN_LSB +: 4] <= RSF_WIN_MAX) begin
                     cfg_q[idx].window <= wdata_i[RSF_CFG_WIN_LSB +: 4];
                  end
                  if (wdata_i[RSF_CFG_UNIT_LSB +: 2] != 2'b11) begin
                     cfg_q[idx].unit <= wdata_i[RSF_CFG_UNIT_LSB +: 2];
                  end
                  cfg_chg_q[idx] <= 1'b1;
               end
               RSF_REG_LIM0: begin
                  lim_q[idx] <= wdata_i[23:0];
                  cfg_chg_q[idx] <= 1'b1;
               end
               RSF_REG_FS0: begin
                  fs_q[idx] <= wdata_i[23:0];
                  cfg_chg_q[idx] <= 1'b1;
               end
               default: begin
                  // low word indexes share the masked value, decode in full
                  if (addr_i == RSF_REG_MASK) begin
                     mask_q <= wdata_i[RSF_NIN-1:0];
                  end
                  if (addr_i == RSF_REG_CMD) begin
                     mm_clr_q <= wdata_i[0];
                  end
               end
            endcase
         end
      end
   end
   // sticky restart events; set wins over read clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_q <= '0;
      end else if (rd_i && addr_i == RSF_REG_STAT) begin
         stat_q <= restart;
      end else begin
         stat_q <= stat_q | restart;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
         ctrl_shutdown_o <= 1'b0;
      end else begin
         irq_o <= |(stat_q & mask_q);
         ctrl_shutdown_o <= |over;
      end
   end
   always_comb begin
      rd_d = 32'h00000000;
      case (addr_i & 6'h3c)
         RSF_REG_CFG0: rd_d = 32'({cfg_q[idx].unit, cfg_q[idx].window,
                                   cfg_q[idx].points, cfg_q[idx].enable});
         RSF_REG_LIM0: rd_d = {8'h00, lim_q[idx]};
         RSF_REG_FS0: rd_d = {8'h00, fs_q[idx]};
         RSF_REG_FILT0: rd_d = {8'h00, filt[idx].value};
         RSF_REG_MAX0: rd_d = {8'h00, mx[idx]};
         RSF_REG_MIN0: rd_d = {8'h00, mn[idx]};
         default: begin
            case (addr_i)
               RSF_REG_CTRL: rd_d = {31'h00000000, ctrl_shutdown_o};
               RSF_REG_STAT: rd_d = {28'h0000000, stat_q};
               RSF_REG_MASK: rd_d = {28'h0000000, mask_q};
               default: rd_d = 32'h00000000;
            endcase
         end
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h00000000;
      end else if (rd_i) begin
         rdata_o <= rd_d;
      end else begin
         rdata_o <= 32'h00000000;
      end
   end
endmodule // rsf_top

//--- rtl/rsf_pkg.sv
// package: constants and carriers for the reading smoothing filter
package rsf_pkg;
   localparam int RSF_NIN = 4;
   localparam int RSF_DW = 24;
   localparam int RSF_FRAC = 8;
   localparam int RSF_AW = 6;
   // register offsets
   localparam logic [5:0] RSF_REG_CTRL = 6'h00;
   localparam logic [5:0] RSF_REG_STAT = 6'h01;
   localparam logic [5:0] RSF_REG_MASK = 6'h02;
   localparam logic [5:0] RSF_REG_CMD = 6'h03;
   localparam logic [5:0] RSF_REG_CFG0 = 6'h08;
   localparam logic [5:0] RSF_REG_LIM0 = 6'h0c;
   localparam logic [5:0] RSF_REG_FS0 = 6'h10;
   localparam logic [5:0] RSF_REG_FILT0 = 6'h14;
   localparam logic [5:0] RSF_REG_MAX0 = 6'h18;
   localparam logic [5:0] RSF_REG_MIN0 = 6'h1c;
   // config field positions
   localparam int RSF_CFG_EN_BIT = 0;
   localparam int RSF_CFG_PTS_LSB = 1;
   localparam int RSF_CFG_WIN_LSB = 8;
   localparam int RSF_CFG_UNIT_LSB = 12;
   // field limits, reset values and percent divider
   localparam logic [6:0] RSF_PTS_MIN = 7'h02;
   localparam logic [6:0] RSF_PTS_MAX = 7'h40;
   localparam logic [6:0] RSF_PTS_RST = 7'h08;
   localparam logic [3:0] RSF_WIN_MIN = 4'h1;
   localparam logic [3:0] RSF_WIN_MAX = 4'ha;
   localparam logic [3:0] RSF_WIN_RST = 4'ha;
   localparam logic [23:0] RSF_LIM_RST = 24'h000000;
   localparam logic [23:0] RSF_FS_RST = 24'hffffff;
   localparam logic [7:0] RSF_PCT_DIV = 8'h64;
   typedef enum logic [1:0] {
      RSF_U_KELVIN = 2'b00,
      RSF_U_CELSIUS = 2'b01,
      RSF_U_SENSOR = 2'b10
   } rsf_unit_e;
   typedef struct packed {
      logic [1:0] unit;
      logic [3:0] window;
      logic [6:0] points;
      logic enable;
   } rsf_cfg_s;
   typedef struct packed {
      logic valid;
      logic [23:0] value;
   } rsf_rdg_s;
endpackage

//--- rtl/rsf_chan.sv
// one input's smoothing, limit and max/min channel
`timescale 1ns/1ps
module rsf_chan
   import rsf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire rsf_cfg_s cfg_i,
   input wire logic cfg_chg_i,
   input wire logic mm_clr_i,
   input wire logic [23:0] limit_i,
   input wire logic [23:0] fs_i,
   input wire rsf_rdg_s rdg_i,
   input wire rsf_rdg_s pref_i,
   output rsf_rdg_s filt_o,
   output logic [23:0] max_o,
   output logic [23:0] min_o,
   output logic over_o,
   output logic restart_o
);
   logic [31:0] acc_q;
   logic primed_q;
   logic en_q;
   logic mm_valid_q;
   logic [23:0] cur;
   logic [23:0] diff;
   logic [31:0] win_abs;
   logic [31:0] x_ext;
   logic [31:0] step;
   logic jump;
   logic [6:0] pts;
   always_comb begin
      pts = cfg_i.points;
      if (pts < RSF_PTS_MIN) begin
         pts = RSF_PTS_MIN;
      end else if (pts > RSF_PTS_MAX) begin
         pts = RSF_PTS_MAX;
      end
      cur = acc_q[31:8];
      diff = (rdg_i.value > cur) ? rdg_i.value - cur : cur - rdg_i.value;
      win_abs = 32'((fs_i * 32'(cfg_i.window)) / 32'(RSF_PCT_DIV));
      jump = primed_q && (32'(diff) > win_abs);
      x_ext = {rdg_i.value, 8'h00};
      // acc += (x - acc) / N : one point per reading, tc = T/ln(N/(N-1))
      if (x_ext >= acc_q) begin
         step = (x_ext - acc_q) / 32'(pts);
      end else begin
         step = -((acc_q - x_ext) / 32'(pts));
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_q <= 32'h00000000;
         primed_q <= 1'b0;
         en_q <= 1'b0;
         restart_o <= 1'b0;
      end else begin
         en_q <= cfg_i.enable;
         restart_o <= 1'b0;
         if (cfg_i.enable && !en_q) begin
            primed_q <= 1'b0;
         end
         if (rdg_i.valid) begin
            if (!cfg_i.enable || !primed_q || (cfg_i.enable && !en_q) || jump) begin
               acc_q <= x_ext;
               primed_q <= cfg_i.enable;
               restart_o <= jump && cfg_i.enable;
            end else begin
               acc_q <= acc_q + step;
            end
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filt_o <= '0;
      end else begin
         filt_o.valid <= rdg_i.valid;
         if (rdg_i.valid) begin
            if (cfg_i.enable && primed_q && en_q && !jump) begin
               filt_o.value <= 24'((acc_q + step) >> RSF_FRAC);
            end else begin
               filt_o.value <= rdg_i.value;
            end
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         over_o <= 1'b0;
      end else if (rdg_i.valid) begin
         over_o <= (limit_i != RSF_LIM_RST) && (rdg_i.value > limit_i);
      end else if (limit_i == RSF_LIM_RST) begin
         over_o <= 1'b0;
      end
   end
   // max/min on the front end's unfiltered reading expressed in preferred units
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         max_o <= 24'h000000;
         min_o <= 24'h000000;
         mm_valid_q <= 1'b0;
      end else if (cfg_chg_i || mm_clr_i) begin
         max_o <= 24'h000000;
         min_o <= 24'h000000;
         mm_valid_q <= 1'b0;
      end else if (pref_i.valid) begin
         mm_valid_q <= 1'b1;
         if (!mm_valid_q || pref_i.value > max_o) begin
            max_o <= pref_i.value;
         end
         if (!mm_valid_q || pref_i.value < min_o) begin
            min_o <= pref_i.value;
         end
      end
   end
endmodule // rsf_chan

//--- bench/rsf_fe_model.sv
// front end model: readings on request and preferred-unit copies
`timescale 1ns/1ps
module rsf_fe_model
   import rsf_pkg::*;
(
   input wire logic clk_i,
   output logic [RSF_NIN-1:0] rdg_valid_o,
   output logic [RSF_NIN*RSF_DW-1:0] rdg_data_o,
   output logic [RSF_NIN-1:0] pref_valid_o,
   output logic [RSF_NIN*RSF_DW-1:0] pref_data_o
);
   initial begin
      rdg_valid_o = '0;
      pref_valid_o = '0;
      rdg_data_o = '0;
      pref_data_o = '0;
   end
   // one strobe per reading, data scrambled between readings
   task automatic send(input int ch, input logic [23:0] v, input logic [23:0] p);
      @(posedge clk_i);
      rdg_valid_o[ch] <= 1'b1;
      pref_valid_o[ch] <= 1'b1;
      rdg_data_o[ch*RSF_DW+:RSF_DW] <= v;
      pref_data_o[ch*RSF_DW+:RSF_DW] <= p;
      @(posedge clk_i);
      rdg_valid_o[ch] <= 1'b0;
      pref_valid_o[ch] <= 1'b0;
      rdg_data_o[ch*RSF_DW+:RSF_DW] <= ~v;
      pref_data_o[ch*RSF_DW+:RSF_DW] <= ~p;
   endtask
endmodule // rsf_fe_model

//--- bench/rsf_props.sv
// checker: port timing assertions for the filter top
`timescale 1ns/1ps
module rsf_props
   import rsf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [5:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [RSF_NIN-1:0] rdg_valid_i,
   input wire logic [RSF_NIN*RSF_DW-1:0] rdg_data_i,
   input wire logic [RSF_NIN-1:0] pref_valid_i,
   input wire logic [RSF_NIN*RSF_DW-1:0] pref_data_i,
   input wire logic [RSF_NIN-1:0] filt_valid_o,
   input wire logic [RSF_NIN*RSF_DW-1:0] filt_data_o,
   input wire logic [RSF_NIN-1:0] ctrl_valid_o,
   input wire logic [RSF_NIN*RSF_DW-1:0] ctrl_data_o,
   input wire logic ctrl_shutdown_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_rdg0;
      rdg_valid_i[0] ##1 filt_valid_o[0];
   endsequence
   chk_filt_rate: assert property (filt_valid_o == $past(rdg_valid_i))
      else $error("filtered strobe not one per reading");
   chk_ctrl_rate: assert property (ctrl_valid_o == $past(rdg_valid_i))
      else $error("control strobe not one per reading");
   chk_ctrl_raw: assert property (s_rdg0 |-> ctrl_data_o[23:0] == $past(rdg_data_i[23:0]))
      else $error("control data not raw");
   chk_filt_hold: assert property (!filt_valid_o[0] |-> $stable(filt_data_o[23:0]))
      else $error("filtered value moved without reading");
   chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside read slot");
   chk_irq_fall: assert property ($fell(irq_o) |-> $past(rd_i, 2) || $past(wr_i, 2))
      else $error("interrupt dropped without access");
   chk_irq_rise: assert property ($rose(irq_o) |->
      $past(|filt_valid_o) || $past(|filt_valid_o, 2) || $past(wr_i, 2))
      else $error("interrupt rose without restart");
   chk_shut_rise: assert property ($rose(ctrl_shutdown_o) |->
      $past(|rdg_valid_i, 2) || $past(|rdg_valid_i, 3) || $past(wr_i, 2))
      else $error("shutdown rose without reading");
endmodule // rsf_props
bind rsf_top rsf_props rsf_props_inst (.*);

//--- bench/test_reading_smoothing_filter.sv
// self-checking bench for the reading smoothing filter
`timescale 1ns/1ps
module test_reading_smoothing_filter
   import rsf_pkg::*;
;
   logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
   logic [5:0] addr_i = '0;
   logic [31:0] wdata_i = '0, rdata_o, d;
   logic [RSF_NIN-1:0] rdg_valid_i, pref_valid_i, filt_valid_o, ctrl_valid_o;
   logic [RSF_NIN*RSF_DW-1:0] rdg_data_i, pref_data_i, filt_data_o, ctrl_data_o;
   logic ctrl_shutdown_o, irq_o;
   int err_count = 0, checks_done = 0;
   always #2.5 clk_i = ~clk_i;
   rsf_top rsf_top_inst (.*);
   rsf_fe_model rsf_fe_model_inst (.clk_i(clk_i), .rdg_valid_o(rdg_valid_i),
      .rdg_data_o(rdg_data_i), .pref_valid_o(pref_valid_i), .pref_data_o(pref_data_i));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic snd(input int ch, input logic [23:0] v);
      rsf_fe_model_inst.send(ch, v, v);
      #1;
   endtask
   task automatic sndp(input int ch, input logic [23:0] v, input logic [23:0] p);
      rsf_fe_model_inst.send(ch, v, p);
      #1;
   endtask
   task automatic hold;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   function automatic logic [23:0] fd(input int ch);
      return filt_data_o[ch*RSF_DW+:RSF_DW];
   endfunction
   task automatic t_defaults;
      rd(RSF_REG_CFG0);
      chk("cfg0", d, 32'h00000a10);
      rd(RSF_REG_FS0);
      chk("fs0", d, 32'h00ffffff);
      rd(RSF_REG_LIM0);
      chk("lim0", d, 32'h0);
      rd(6'h3f);
      chk("unmapped", d, 32'h0);
      $display("done defaults");
   endtask
   task automatic t_smooth;
      wr(RSF_REG_FS0, 32'h3e8);
      wr(RSF_REG_CFG0, 32'h105);
      wr(RSF_REG_CFG0, 32'h183);
      rd(RSF_REG_CFG0);
      chk("cfg0", d, 32'h105);
      snd(0, 24'h000100);
      chk("load", fd(0), 24'h000100);
      snd(0, 24'h00010a);
      chk("avg", fd(0), 24'h000105);
      rd(RSF_REG_STAT);
      chk("stat idle", d, 32'h0);
      wr(RSF_REG_MASK, 32'h1);
      rd(RSF_REG_MASK);
      chk("mask", d, 32'h1);
      snd(0, 24'h000110);
      chk("restart", fd(0), 24'h000110);
      hold();
      chk("irq on", irq_o, 1'b1);
      rd(RSF_REG_STAT);
      chk("stat", d, 32'h1);
      hold();
      chk("irq off", irq_o, 1'b0);
      rd(RSF_REG_FILT0);
      chk("filt reg", d, 32'h110);
      $display("done smooth");
   endtask
   task automatic t_settle;
      wr(RSF_REG_CFG0 + 6'h01, 32'ha11);
      snd(1, 24'h001000);
      snd(1, 24'h011000);
      chk("step one", fd(1), 24'h003000);
      repeat (44) snd(1, 24'h011000);
      chk("settle", (24'h011000 - fd(1)) <= 24'h0000c8, 1'b1);
      chk("ctrl raw", ctrl_data_o[47:24], 24'h011000);
      $display("done settle");
   endtask
   task automatic t_maxmin;
      snd(2, 24'h000032);
      chk("raw", fd(2), 24'h000032);
      snd(2, 24'h000014);
      snd(2, 24'h000050);
      rd(RSF_REG_MAX0 + 6'h02);
      chk("max", d, 32'h50);
      rd(RSF_REG_MIN0 + 6'h02);
      chk("min", d, 32'h14);
      wr(RSF_REG_CMD, 32'h1);
      rd(RSF_REG_MAX0 + 6'h02);
      chk("max clr", d, 32'h0);
      snd(2, 24'h000020);
      wr(RSF_REG_LIM0 + 6'h02, 32'h0);
      rd(RSF_REG_MIN0 + 6'h02);
      chk("min cfg clr", d, 32'h0);
      wr(RSF_REG_CFG0 + 6'h02, 32'h1a10);
      rd(RSF_REG_CFG0 + 6'h02);
      chk("unit", d, 32'h1a10);
      sndp(2, 24'h000040, 24'h000005);
      rd(RSF_REG_MIN0 + 6'h02);
      chk("min pref", d, 32'h5);
      $display("done maxmin");
   endtask
   task automatic t_limit;
      wr(RSF_REG_LIM0 + 6'h03, 32'h64);
      snd(3, 24'h000064);
      hold();
      chk("at limit", ctrl_shutdown_o, 1'b0);
      snd(3, 24'h000065);
      hold();
      chk("over", ctrl_shutdown_o, 1'b1);
      rd(RSF_REG_CTRL);
      chk("ctrl reg", d, 32'h1);
      wr(RSF_REG_LIM0 + 6'h03, 32'h0);
      snd(3, 24'hffffff);
      hold();
      chk("lim off", ctrl_shutdown_o, 1'b0);
      $display("done limit");
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_defaults();
      t_smooth();
      t_settle();
      t_maxmin();
      t_limit();
      close_out();
   end
endmodule // test_reading_smoothing_filter
